// ---- tmr16_pkg.sv ----
`default_nettype none
package tmr16_pkg;
    // I/O bus and counter widths
    localparam int IO_AW = 8;
    localparam int IO_DW = 8;
    localparam int CNT_W = 16;

    // I/O addresses
    localparam logic [7:0] ADDR_REQ  = 8'h05;
    localparam logic [7:0] ADDR_MODE = 8'h06;
    localparam logic [7:0] ADDR_EDGE = 8'h0c;

    // Mode register fields
    localparam int SRC_MSB = 7;
    localparam int SRC_LSB = 5;
    localparam int PRE_MSB = 4;
    localparam int PRE_LSB = 3;
    localparam int BIT_MSB = 2;
    localparam int BIT_LSB = 0;

    // Edge select and request flag positions
    localparam int EDGE_POS = 4;
    localparam int REQ_POS  = 2;

    // Reset values
    localparam logic [7:0]  MODE_RST = 8'h00;
    localparam logic        EDGE_RST = 1'b0;
    localparam logic        REQ_RST  = 1'b0;
    localparam logic [15:0] CNT_RST  = 16'h0000;

    // Trigger bit index is 8 plus the field, so the top bit is set
    localparam logic TRIG_HI = 1'b1;

    // Number of asynchronous clock sources
    localparam int NSRC = 5;

    // Clock source codes
    typedef enum logic [2:0] {
        SRC_STOP   = 3'b000,
        SRC_SYS    = 3'b001,
        SRC_UNUSED = 3'b010,
        SRC_PIN_A4 = 3'b011,
        SRC_HIGH_RC = 3'b100,
        SRC_CRYSTAL = 3'b101,
        SRC_LOW_RC = 3'b110,
        SRC_PIN_A0 = 3'b111
    } tmr16_src_e;

    // Prescale codes
    typedef enum logic [1:0] {
        PRE_DIV1  = 2'b00,
        PRE_DIV4  = 2'b01,
        PRE_DIV16 = 2'b10,
        PRE_DIV64 = 2'b11
    } tmr16_pre_e;
endpackage : tmr16_pkg
`default_nettype wire

// ---- tmr16_src_if.sv ----
`default_nettype none
interface tmr16_src_if;
    logic [2:0] src;   // Selected clock source code
    logic       tick;  // One-cycle pulse per rising source clock edge

    modport sel  (input src, output tick);
    modport core (output src, input tick);
endinterface : tmr16_src_if
`default_nettype wire

// ---- tmr16_src_sel.sv ----
`default_nettype none
module tmr16_src_sel
    import tmr16_pkg::*;
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Raw clock sources: pin A4, high RC, crystal, low RC, pin A0
    input  wire logic [NSRC-1:0]  src_raw,
    // Toward the counter core
    tmr16_src_if.sel              sif
);
    logic [NSRC-1:0] s1_q, s1_d;
    logic [NSRC-1:0] s2_q, s2_d;
    logic [NSRC-1:0] s3_q, s3_d;
    logic [NSRC-1:0] rise;
    logic            tick_q, tick_d;

    // Two-stage synchroniser plus one history stage for edge detect
    always_comb begin
        s1_d = src_raw;
        s2_d = s1_q;
        s3_d = s2_q;
        rise = s2_q & ~s3_q;
        // [R11] count pin edges
        unique case (tmr16_src_e'(sif.src))
            SRC_STOP:    tick_d = 1'b0;
            SRC_SYS:     tick_d = 1'b1;
            SRC_UNUSED:  tick_d = 1'b0;
            SRC_PIN_A4:  tick_d = rise[0];
            SRC_HIGH_RC: tick_d = rise[1];
            SRC_CRYSTAL: tick_d = rise[2];
            SRC_LOW_RC:  tick_d = rise[3];
            SRC_PIN_A0:  tick_d = rise[4];
        endcase
    end

    // Register stage; tick is a clean one-cycle pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q   <= '0;
            s2_q   <= '0;
            s3_q   <= '0;
            tick_q <= 1'b0;
        end else begin
            s1_q   <= s1_d;
            s2_q   <= s2_d;
            s3_q   <= s3_d;
            tick_q <= tick_d;
        end
    end

    assign sif.tick = tick_q;
endmodule : tmr16_src_sel
`default_nettype wire

// ---- tmr16_timer.sv ----
// Operation
// [R1] Three-bit source field picks stop, system, pins, RC or crystal clock.
// [R2] Selected clock is divided by 1, 4, 16 or 64 from a field.
// [R3] Sixteen-bit counter only counts up by one per prescaled tick.
// [R4] Store instruction loads the counter; read instruction returns the count.
// [R5] Trigger bit is counter bit 8 plus a three-bit field.
// [R6] Edge select bit 4 at address 0x0C picks rising or falling trigger.
// [R7] Each qualifying trigger transition sets request flag bit 2.
// [R8] Free running request rate is source over prescale over 2^(n+1).
// [R9] Mode register at I/O address 0x06 is readable and writable.
// [R10] Bit 13, start zero: request sets when count reaches 0x2000.
// [R11] Pin clock sources are synchronised; one count per detected edge.
// [R12] Counter wraps from 0xffff to zero and keeps counting.
`default_nettype none
module tmr16_timer
    import tmr16_pkg::*;
(
    // Clock and reset
    input  wire logic                       CLOCK_IN,
    input  wire logic                       RST_IN,
    // Clock sources, sampled on CLOCK_IN
    input  wire logic                       PIN_A4_CLOCK_IN,
    input  wire logic                       HIGH_RC_OSCILLATOR_IN,
    input  wire logic                       CRYSTAL_OSCILLATOR_IN,
    input  wire logic                       LOW_RC_OSCILLATOR_IN,
    input  wire logic                       PIN_A0_CLOCK_IN,
    // I/O register port
    input  wire logic [tmr16_pkg::IO_AW-1:0] IO_ADDR_IN,
    input  wire logic                       IO_WR_IN,
    input  wire logic                       IO_RD_IN,
    input  wire logic [tmr16_pkg::IO_DW-1:0] IO_WDATA_IN,
    output var  logic [tmr16_pkg::IO_DW-1:0] IO_RDATA_OUT,
    // Counter store and read instructions
    input  wire logic                       CNT_STORE_IN,
    input  wire logic [tmr16_pkg::CNT_W-1:0] CNT_STORE_DATA_IN,
    input  wire logic                       CNT_READ_IN,
    output var  logic [tmr16_pkg::CNT_W-1:0] CNT_READ_DATA_OUT,
    output var  logic                       CNT_READ_VALID_OUT,
    // Timer request flag
    output var  logic                       TIMER_REQ_OUT
);
    tmr16_src_if sif ();

    logic [7:0]       mode_q, mode_d;
    logic             edge_q, edge_d;
    logic             req_q, req_d;
    logic [CNT_W-1:0] cnt_q, cnt_d, cnt_inc;
    logic [5:0]       pre_q, pre_d, pre_mask;
    logic [7:0]       rdata_q, rdata_d;
    logic [CNT_W-1:0] rd_q, rd_d;
    logic             rdv_q, rdv_d;
    logic             cnt_en, trig, old_bit, new_bit;
    logic [3:0]       trig_idx;

    // [R1] source select and synchroniser
    assign sif.src = mode_q[SRC_MSB:SRC_LSB];

    tmr16_src_sel u_src (
        .clk     (CLOCK_IN),
        .rst     (RST_IN),
        .src_raw ({PIN_A0_CLOCK_IN, LOW_RC_OSCILLATOR_IN,
                   CRYSTAL_OSCILLATOR_IN, HIGH_RC_OSCILLATOR_IN,
                   PIN_A4_CLOCK_IN}),
        .sif     (sif)
    );

    // Prescaler, counter, trigger and register next state
    always_comb begin
        // [R2] prescale mask
        unique case (tmr16_pre_e'(mode_q[PRE_MSB:PRE_LSB]))
            PRE_DIV1:  pre_mask = 6'h00;
            PRE_DIV4:  pre_mask = 6'h03;
            PRE_DIV16: pre_mask = 6'h0f;
            PRE_DIV64: pre_mask = 6'h3f;
        endcase
        pre_d  = sif.tick ? pre_q + 6'h01 : pre_q;
        cnt_en = sif.tick && ((pre_q & pre_mask) == pre_mask);
        // [R3] up count only; [R12] natural wrap at full scale
        cnt_inc = cnt_q + 16'h0001;
        // [R5] trigger bit index 8 to 15
        trig_idx = {TRIG_HI, mode_q[BIT_MSB:BIT_LSB]};
        old_bit  = cnt_q[trig_idx];
        new_bit  = cnt_inc[trig_idx];
        // [R6] edge choice; [R8] [R10] only counting can trigger
        trig = cnt_en && (old_bit != new_bit) && (new_bit != edge_q);
        cnt_d = cnt_q;
        // [R4] store wins over a count in the same cycle
        if (CNT_STORE_IN) begin
            cnt_d = CNT_STORE_DATA_IN;
        end else if (cnt_en) begin
            cnt_d = cnt_inc;
        end
        // [R4] read instruction returns current count
        rdv_d = CNT_READ_IN;
        rd_d  = CNT_READ_IN ? cnt_q : rd_q;
        // [R9] mode register write; edge and request registers likewise
        mode_d = (IO_WR_IN && IO_ADDR_IN == ADDR_MODE) ? IO_WDATA_IN : mode_q;
        edge_d = (IO_WR_IN && IO_ADDR_IN == ADDR_EDGE) ?
                 IO_WDATA_IN[EDGE_POS] : edge_q;
        req_d  = (IO_WR_IN && IO_ADDR_IN == ADDR_REQ) ?
                 IO_WDATA_IN[REQ_POS] : req_q;
        // [R7] hardware set beats a software clear
        if (trig) begin
            req_d = 1'b1;
        end
        // Register read mux; unmapped addresses read zero
        rdata_d = rdata_q;
        if (IO_RD_IN) begin
            rdata_d = 8'h00;
            if (IO_ADDR_IN == ADDR_MODE) begin
                rdata_d = mode_q;
            end else if (IO_ADDR_IN == ADDR_EDGE) begin
                rdata_d[EDGE_POS] = edge_q;
            end else if (IO_ADDR_IN == ADDR_REQ) begin
                rdata_d[REQ_POS] = req_q;
            end
        end
    end

    // State registers
    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            mode_q  <= MODE_RST;
            edge_q  <= EDGE_RST;
            req_q   <= REQ_RST;
            cnt_q   <= CNT_RST;
            pre_q   <= 6'h00;
            rdata_q <= 8'h00;
            rd_q    <= CNT_RST;
            rdv_q   <= 1'b0;
        end else begin
            mode_q  <= mode_d;
            edge_q  <= edge_d;
            req_q   <= req_d;
            cnt_q   <= cnt_d;
            pre_q   <= pre_d;
            rdata_q <= rdata_d;
            rd_q    <= rd_d;
            rdv_q   <= rdv_d;
        end
    end

    // Outputs straight from flip-flops
    assign IO_RDATA_OUT       = rdata_q;
    assign CNT_READ_DATA_OUT  = rd_q;
    assign CNT_READ_VALID_OUT = rdv_q;
    assign TIMER_REQ_OUT      = req_q;

    // Checks on the counter and request logic
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (RST_IN);

    sequence s_rise_step;
        cnt_en && !CNT_STORE_IN && !edge_q && !old_bit && new_bit;
    endsequence

    sequence s_fall_step;
        cnt_en && !CNT_STORE_IN && edge_q && old_bit && !new_bit;
    endsequence

    a_stop_no_tick: assert property ( // [R1]
        mode_q[SRC_MSB:SRC_LSB] == SRC_STOP &&
        $past(mode_q[SRC_MSB:SRC_LSB]) == SRC_STOP |-> !sif.tick)
        else $error("Tick seen while source stopped");

    // Boundary worked out from the field itself, not from the mask logic
    a_prescale_gate: assert property ( // [R2]
        cnt_en |-> sif.tick &&
        (mode_q[PRE_MSB:PRE_LSB] == PRE_DIV1 || pre_q[1:0] == 2'h3) &&
        (mode_q[PRE_MSB:PRE_LSB] <= PRE_DIV4 || pre_q[3:2] == 2'h3) &&
        (mode_q[PRE_MSB:PRE_LSB] != PRE_DIV64 || pre_q[5:4] == 2'h3))
        else $error("Count enable outside prescale boundary");

    a_count_step: assert property ( // [R3]
        cnt_en && !CNT_STORE_IN |=> cnt_q == $past(cnt_q) + 16'h0001)
        else $error("Counter did not step by one");

    a_count_hold: assert property ( // [R3]
        !cnt_en && !CNT_STORE_IN |=> $stable(cnt_q))
        else $error("Counter moved without a tick");

    a_store_load: assert property ( // [R4]
        CNT_STORE_IN |=> cnt_q == $past(CNT_STORE_DATA_IN))
        else $error("Store value not loaded");

    a_read_back: assert property ( // [R4]
        CNT_READ_IN |=> CNT_READ_VALID_OUT &&
        CNT_READ_DATA_OUT == $past(cnt_q))
        else $error("Read returned wrong count");

    a_rise_request: assert property ( // [R7]
        s_rise_step |=> TIMER_REQ_OUT)
        else $error("Rising trigger did not set request");

    a_fall_request: assert property ( // [R6]
        s_fall_step |=> TIMER_REQ_OUT)
        else $error("Falling trigger did not set request");

    a_bit13_mark: assert property ( // [R10]
        mode_q[BIT_MSB:BIT_LSB] == 3'h5 && !edge_q && !CNT_STORE_IN &&
        cnt_en && cnt_q == 16'h1fff |=> TIMER_REQ_OUT && cnt_q == 16'h2000)
        else $error("No request on reaching 0x2000");

    a_counter_wrap: assert property ( // [R12]
        cnt_en && !CNT_STORE_IN && cnt_q == 16'hffff |=> cnt_q == 16'h0000)
        else $error("Counter failed to wrap");

    a_mode_write: assert property ( // [R9]
        IO_WR_IN && IO_ADDR_IN == ADDR_MODE |=> mode_q == $past(IO_WDATA_IN))
        else $error("Mode register write lost");

    a_mode_read: assert property ( // [R9]
        IO_RD_IN && IO_ADDR_IN == ADDR_MODE |=> IO_RDATA_OUT == $past(mode_q))
        else $error("Mode register readback mismatch");

    // Valid is a single pulse; a stuck valid would fool the core
    a_read_pulse: assert property ( // [R4]
        !CNT_READ_IN |=> !CNT_READ_VALID_OUT)
        else $error("Read valid without a read");

    // Stores and idle cycles never raise the request on their own
    a_request_cause: assert property ( // [R7]
        !trig && !IO_WR_IN |=> !$rose(TIMER_REQ_OUT))
        else $error("Request raised without a trigger");
endmodule : tmr16_timer
`default_nettype wire

// ---- tmr16_core_mdl.sv ----
`default_nettype none
// Core model: issues one I/O or counter instruction per call
module tmr16_core_mdl (
    // Clock
    input  wire logic        clk_in,
    // Requests toward the timer
    output var  logic [7:0]  addr_out,
    output var  logic        wr_out,
    output var  logic        rd_out,
    output var  logic [7:0]  wdata_out,
    output var  logic        st_out,
    output var  logic [15:0] sdata_out,
    output var  logic        crd_out,
    // Answers from the timer
    input  wire logic [7:0]  rdata_in,
    input  wire logic [15:0] cdata_in,
    input  wire logic        cval_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle at time zero
    initial begin
        {addr_out, wdata_out, sdata_out} = '0;
        {wr_out, rd_out, st_out, crd_out} = '0;
    end

    // store and read
    // Op 0 write, 1 read, 2 counter store, 3 counter read
    task automatic io(input logic [1:0] op, input logic [15:0] d,
                      input logic [7:0] a, output logic [16:0] q);
        @(negedge clk_in);
        addr_out = a;
        wdata_out = d[7:0];
        sdata_out = d;
        wr_out = (op == 2'd0);
        rd_out = (op == 2'd1);
        st_out = (op == 2'd2);
        crd_out = (op == 2'd3);
        @(negedge clk_in);
        {wr_out, rd_out, st_out, crd_out} = '0;
        q = (op == 2'd3) ? {cval_in, cdata_in} : {9'h000, rdata_in};
        // Stale values must not look valid once released
        addr_out = ~addr_out;
        wdata_out = ~wdata_out;
        sdata_out = ~sdata_out;
    endtask
endmodule // tmr16_core_mdl
`default_nettype wire

// ---- tmr16_timer_tb.sv ----
`default_nettype none
`define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin \
    err_count++; $display("Error %s exp %h got %h", nm, e, a); end end
module tmr16_timer_tb
    import tmr16_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [4:0]  src = '0;  // A4, high RC, crystal, low RC, A0
    logic [7:0]  addr, wdata, rdata;
    logic        wr, rd, st, crd, cval, req, hit;
    logic [15:0] sdata, cdata;
    logic [16:0] q;
    int          err_count = 0;
    int          comparisons = 0;
    int          cyc = 0;
    int          t1, m_cnt;
    int          m_per[$];

    tmr16_timer i_tmr16_timer (
        .CLOCK_IN(clk), .RST_IN(rst), .PIN_A4_CLOCK_IN(src[0]),
        .HIGH_RC_OSCILLATOR_IN(src[1]), .CRYSTAL_OSCILLATOR_IN(src[2]),
        .LOW_RC_OSCILLATOR_IN(src[3]), .PIN_A0_CLOCK_IN(src[4]),
        .IO_ADDR_IN(addr), .IO_WR_IN(wr), .IO_RD_IN(rd),
        .IO_WDATA_IN(wdata), .IO_RDATA_OUT(rdata), .CNT_STORE_IN(st),
        .CNT_STORE_DATA_IN(sdata), .CNT_READ_IN(crd),
        .CNT_READ_DATA_OUT(cdata), .CNT_READ_VALID_OUT(cval),
        .TIMER_REQ_OUT(req));

    tmr16_core_mdl i_tmr16_core_mdl (
        .clk_in(clk), .addr_out(addr), .wr_out(wr), .rd_out(rd),
        .wdata_out(wdata), .st_out(st), .sdata_out(sdata),
        .crd_out(crd), .rdata_in(rdata), .cdata_in(cdata),
        .cval_in(cval));

    // Clock and hang guard; longest run is the /64 period
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc > 90000) begin
            err_count++;
            stop_test();
        end
    end

    task automatic wio(input logic [7:0] a, input logic [7:0] d);
        i_tmr16_core_mdl.io(2'd0, {8'h00, d}, a, q);
    endtask
    task automatic rio(input logic [7:0] a);
        i_tmr16_core_mdl.io(2'd1, 16'h0000, a, q);
    endtask
    task automatic cnt(input logic [1:0] op, input logic [15:0] d);
        i_tmr16_core_mdl.io(op, d, 8'h00, q);
    endtask

    // Bounded wait for the request flag
    task automatic wait_req(input int n);
        for (int i = 0; i < n && req !== 1'b1; i++) @(negedge clk);
        hit = (req === 1'b1);
    endtask

    // Source j sees j+1 rising edges, levels held three cycles
    task automatic pulse_src();
        for (int e = 0; e < 5; e++) begin
            @(negedge clk);
            src = 5'(5'h1f << e);
            repeat (3) @(negedge clk);
            src = '0;
            repeat (2) @(negedge clk);
        end
    endtask

    task automatic stop_test();
        $display("Checks %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        void'($urandom(32'hf22c));
        repeat (5) @(negedge clk);
        rst = 1'b0;
        rio(ADDR_MODE);
        `CHK("mode", MODE_RST, q[7:0])
        m_cnt = $urandom_range(255);
        wio(ADDR_MODE, 8'(m_cnt));
        wio(8'h07, 8'hff);
        rio(ADDR_MODE);
        `CHK("mode", 8'(m_cnt), q[7:0])
        rio(8'h07);
        `CHK("unmapped", 8'h00, q[7:0])
        // source select, system clock timed below
        for (int s = 0; s < 8; s++) begin
            if (s == 1) continue;
            wio(ADDR_MODE, 8'(s << SRC_LSB));
            m_cnt = $urandom_range(16'hffff);
            cnt(2'd2, 16'(m_cnt));
            pulse_src();
            repeat (8) @(negedge clk);
            if (s >= 3) m_cnt += s - 2;
            cnt(2'd3, 16'h0000);
            `CHK("count", 16'(m_cnt), q[15:0])
            `CHK("valid", 1'b1, q[16])
        end
        // bit and edge select, wrap at f=7
        for (int e = 0; e < 2; e++) begin
            wio(ADDR_EDGE, 8'(e << EDGE_POS));
            rio(ADDR_EDGE);
            `CHK("edge", 8'(e << EDGE_POS), q[7:0])
            for (int f = 0; f < 8; f++) begin
                wio(ADDR_MODE, 8'h20 | 8'(f));
                for (int k = 0; k < 2; k++) begin
                    cnt(2'd2, 16'((1 << (8 + f + (k ^ e))) - 8));
                    wio(ADDR_REQ, 8'h00);
                    wait_req(20);
                    `CHK("request", (k == 0), hit)
                    rio(ADDR_REQ);
                    `CHK("flag", 8'(k == 0) << REQ_POS, q[7:0])
                end
            end
        end
        wio(ADDR_EDGE, 8'h00);
        for (int p = 0; p < 4; p++) begin
            wio(ADDR_MODE, 8'h20 | 8'(p << PRE_LSB));
            cnt(2'd2, 16'h00f8);
            wio(ADDR_REQ, 8'h00);
            wait_req(40000);
            t1 = cyc;
            wio(ADDR_REQ, 8'h00);
            wait_req(40000);
            m_per.push_back(512 << (2 * p));
            // Pop once; the check macro reads its expected value twice
            m_cnt = m_per.pop_front();
            `CHK("period", m_cnt, cyc - t1)
        end
        stop_test();
    end
endmodule // tmr16_timer_tb
`default_nettype wire
